//--- bit_test_skip_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end

module bit_test_skip_decoder_test;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [15:0] instr_word = 16'h0000;
   logic        instr_valid = 1'b0;
   logic        two_word = 1'b0;
   logic [3:0]  bank_sel = 4'h0;
   logic        ext = 1'b0;
   logic [11:0] base = 12'h000;
   logic [7:0]  rd_data;
   logic [1:0]  q_phase;
   logic [11:0] data_addr;
   logic        rd_en, data_we, status_we, skip_taken, discard_fetch, nop_active, test_active;
   int          error_cnt = 0;
   int          n_tests = 0;

   always #20 mclk = ~mclk;

   btsd_mem_model u_mem (.rd_en(rd_en), .addr(data_addr), .rd_data(rd_data));

   btsd_decoder u_dut (.mclk(mclk), .sys_rst(sys_rst), .instr_word(instr_word), .instr_valid(instr_valid),
      .next_two_word(two_word), .bank_select_reg(bank_sel), .ext_set_en(ext), .index_base(base),
      .data_rd_data(rd_data), .q_phase(q_phase), .data_addr(data_addr), .data_rd_en(rd_en),
      .data_we(data_we), .status_we(status_we), .skip_taken(skip_taken), .discard_fetch(discard_fetch),
      .nop_active(nop_active), .test_active(test_active));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic tick;
      @(posedge mclk);
      #1;
   endtask

   task automatic wait_q0;
      int i;
      for (i = 0; i < 16 && (q_phase !== 2'h0 || nop_active !== 1'b0); i++) tick;
      if (q_phase !== 2'h0 || nop_active !== 1'b0) begin
         error_cnt++;
         final_report;
      end
   endtask

   // One bit test: bit forced to want, expected address and skip length
   task automatic do_test(input logic [3:0] op, input logic [2:0] b, input logic a, input logic [7:0] f,
                          input logic [11:0] ea, input logic want, input logic two, input logic sk);
      int i, n;
      wait_q0;
      u_mem.mem[ea] = want ? (8'h01 << b) : ~(8'h01 << b);
      instr_word = {op, b, a, f};
      instr_valid = 1'b1;
      two_word = two;
      tick;
      instr_valid = 1'b0;
      `CHK(test_active, 1'b1)
      `CHK(data_addr, ea)
      `CHK(rd_en, 1'b1)
      tick;
      tick;
      `CHK(skip_taken, sk)
      `CHK(discard_fetch, sk)
      n = 0;
      for (i = 0; i < 12; i++) begin
         tick;
         n += (nop_active === 1'b1);
         `CHK(data_we | status_we, 1'b0)
      end
      `CHK(n, sk ? (two ? 8 : 4) : 0)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_clear;
      bank_sel = 4'h3;
      do_test(4'hb, 3'h7, 1'b1, 8'h22, 12'h322, 1'b0, 1'b0, 1'b1);
      do_test(4'hb, 3'h7, 1'b1, 8'h22, 12'h322, 1'b1, 1'b1, 1'b0);
   endtask

   task automatic s_set;
      do_test(4'ha, 3'h0, 1'b1, 8'h40, 12'h340, 1'b1, 1'b1, 1'b1);
      do_test(4'ha, 3'h0, 1'b1, 8'h40, 12'h340, 1'b0, 1'b1, 1'b0);
      do_test(4'ha, 3'h4, 1'b1, 8'h41, 12'h341, 1'b1, 1'b0, 1'b1);
   endtask

   task automatic s_bank;
      do_test(4'ha, 3'h2, 1'b0, 8'h5f, 12'h05f, 1'b0, 1'b0, 1'b0);
      do_test(4'ha, 3'h2, 1'b0, 8'h60, 12'hf60, 1'b0, 1'b0, 1'b0);
      ext = 1'b1;
      base = 12'hfff;
      do_test(4'ha, 3'h2, 1'b0, 8'h5f, 12'h05e, 1'b0, 1'b0, 1'b0);
      do_test(4'ha, 3'h2, 1'b0, 8'h60, 12'hf60, 1'b0, 1'b0, 1'b0);
      bank_sel = 4'hf;
      do_test(4'hb, 3'h5, 1'b1, 8'h10, 12'hf10, 1'b1, 1'b0, 1'b0);
   endtask

   task automatic s_other;
      int i;
      wait_q0;
      instr_word = 16'h8e22;
      instr_valid = 1'b1;
      for (i = 0; i < 4; i++) begin
         tick;
         `CHK(test_active, 1'b0)
      end
      instr_valid = 1'b0;
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      #1;
      `CHK(q_phase, 2'h0)
      sys_rst = 1'b0;
      s_clear;
      s_set;
      s_bank;
      s_other;
      final_report;
   end
endmodule // bit_test_skip_decoder_test

`default_nettype wire

//--- btsd_addr_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "btsd_consts.svh"

module btsd_addr_gen (
   input  wire logic [7:0]  reg_field,
   input  wire logic        bank_flag,
   input  wire logic [3:0]  bank_select_reg,
   input  wire logic        ext_set_en,
   input  wire logic [11:0] index_base,
   output logic      [11:0] addr
);

   always_comb begin
      if (bank_flag) begin
         addr = {bank_select_reg, reg_field};
      end else if (ext_set_en && (reg_field <= `BTSD_ACCESS_LIM)) begin
         addr = 12'(index_base + {4'h0, reg_field});
      end else if (reg_field <= `BTSD_ACCESS_LIM) begin
         addr = {`BTSD_ACCESS_LO, reg_field};
      end else begin
         addr = {`BTSD_ACCESS_HI, reg_field};
      end
   end

endmodule // btsd_addr_gen
`default_nettype wire

//--- btsd_consts.svh
`ifndef BTSD_CONSTS_SVH
`define BTSD_CONSTS_SVH

// Opcode nibbles of the two bit-test instructions
`define BTSD_OP_SET      4'ha
`define BTSD_OP_CLR      4'hb
// Instruction word fields
`define BTSD_OP_MSB      15
`define BTSD_OP_LSB      12
`define BTSD_BIT_MSB     11
`define BTSD_BIT_LSB     9
`define BTSD_BANK_FLAG   8
`define BTSD_REG_MSB     7
`define BTSD_REG_LSB     0
// Access bank split and its upper page
`define BTSD_ACCESS_LIM  8'h5f
`define BTSD_ACCESS_HI   4'hf
`define BTSD_ACCESS_LO   4'h0
// Quarter phases of one instruction cycle, one per clock
`define BTSD_Q1          2'h0
`define BTSD_Q2          2'h1
`define BTSD_Q3          2'h2
`define BTSD_Q4          2'h3

`endif

//--- btsd_decoder.sv
// Functional notes
// - Skip-if-clear skips the next instruction when the tested bit is zero.
// - Skip-if-set skips the next instruction when the tested bit is one.
// - A taken skip discards the prefetched word and runs one no-op cycle.
// - Skipping a two-word instruction adds a second no-op cycle, two in all.
// - Single word; one cycle without skip, two with skip, three when the skipped instruction is two-word.
// - Bank flag zero picks the access bank, one picks bank_select_reg bank.
// - Flag zero with extended set and field up to 95 uses indexed offset.
// - Skip-if-set opcode is 1010, bit index, bank flag, register address.
`timescale 1ns/1ns
`default_nettype none
`include "btsd_consts.svh"

module btsd_decoder (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_valid,
   input  wire logic        next_two_word,
   input  wire logic [3:0]  bank_select_reg,
   input  wire logic        ext_set_en,
   input  wire logic [11:0] index_base,
   input  wire logic [7:0]  data_rd_data,
   output logic      [1:0]  q_phase,
   output logic      [11:0] data_addr,
   output logic             data_rd_en,
   output logic             data_we,
   output logic             status_we,
   output logic             skip_taken,
   output logic             discard_fetch,
   output logic             nop_active,
   output logic             test_active
);

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic is_btest(input logic [15:0] w);
      is_btest = (w[`BTSD_OP_MSB:`BTSD_OP_LSB] == `BTSD_OP_SET) ||
                 (w[`BTSD_OP_MSB:`BTSD_OP_LSB] == `BTSD_OP_CLR);
   endfunction

   function automatic logic is_set_op(input logic [15:0] w);
      is_set_op = (w[`BTSD_OP_MSB:`BTSD_OP_LSB] == `BTSD_OP_SET);
   endfunction

   btsd_pkg::btsd_state_t state;
   btsd_pkg::btsd_state_t next_state;
   logic [2:0]            ir_bit;
   logic                  ir_set;
   logic                  two_word;
   logic                  accept;
   logic                  rd_bit;
   logic [11:0]           next_addr;

   assign accept = (state == btsd_pkg::BTSD_EXEC) && (q_phase == `BTSD_Q1) &&
                   instr_valid && is_btest(instr_word);
   assign rd_bit = data_rd_data[ir_bit];

   btsd_addr_gen u_addr (
      .reg_field       (instr_word[`BTSD_REG_MSB:`BTSD_REG_LSB]),
      .bank_flag       (instr_word[`BTSD_BANK_FLAG]),
      .bank_select_reg (bank_select_reg),
      .ext_set_en      (ext_set_en),
      .index_base      (index_base),
      .addr            (next_addr)
   );

   ////////////////////////////////////////////////////////////////////////
   // Quarter phase counter

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         q_phase <= `BTSD_Q1;
      end else begin
         q_phase <= 2'(q_phase + 2'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction latch and register read

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ir_bit      <= 3'h0;
         ir_set      <= 1'b0;
         test_active <= 1'b0;
         data_addr   <= 12'h000;
      end else if (accept) begin
         ir_bit      <= instr_word[`BTSD_BIT_MSB:`BTSD_BIT_LSB];
         ir_set      <= is_set_op(instr_word);
         test_active <= 1'b1;
         data_addr   <= next_addr;
      end else if (q_phase == `BTSD_Q4) begin
         test_active <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         data_rd_en <= 1'b0;
      end else if (accept) begin
         data_rd_en <= 1'b1;
      end else if (q_phase == `BTSD_Q3) begin
         data_rd_en <= 1'b0;
      end
   end

   // The tested register and the status flags are never written
   assign data_we   = 1'b0;
   assign status_we = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Skip decision

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         skip_taken <= 1'b0;
      end else if (q_phase == `BTSD_Q1) begin
         skip_taken <= 1'b0;
      end else if (q_phase == `BTSD_Q3 && test_active) begin
         skip_taken <= (rd_bit == ir_set);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // No-op cycle sequencing

   always_comb begin
      next_state = state;
      case (state)
         btsd_pkg::BTSD_EXEC: begin
            if (skip_taken) begin
               next_state = btsd_pkg::BTSD_NOP1;
            end
         end
         btsd_pkg::BTSD_NOP1: begin
            next_state = two_word ? btsd_pkg::BTSD_NOP2 : btsd_pkg::BTSD_EXEC;
         end
         btsd_pkg::BTSD_NOP2: begin
            next_state = btsd_pkg::BTSD_EXEC;
         end
         default: begin
            next_state = btsd_pkg::BTSD_EXEC;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= btsd_pkg::BTSD_EXEC;
      end else if (q_phase == `BTSD_Q4) begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         two_word <= 1'b0;
      end else if (q_phase == `BTSD_Q4 && state == btsd_pkg::BTSD_EXEC && skip_taken) begin
         two_word <= next_two_word;
      end
   end

   assign discard_fetch = (state == btsd_pkg::BTSD_EXEC) && (q_phase == `BTSD_Q4) &&
                          skip_taken;
   assign nop_active    = (state != btsd_pkg::BTSD_EXEC);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_clear_skip: assert property ((test_active && q_phase == `BTSD_Q3 && !ir_set && !rd_bit)
      |=> skip_taken) else $error("clear test with zero bit did not skip");

   a_set_skip: assert property ((test_active && q_phase == `BTSD_Q3 && ir_set && rd_bit)
      |=> skip_taken) else $error("set test with one bit did not skip");

   a_one_nop: assert property ((discard_fetch && !next_two_word)
      |=> nop_active [*4] ##1 !nop_active) else $error("single no-op cycle length wrong");

   a_two_nops: assert property ((discard_fetch && next_two_word)
      |=> nop_active [*8] ##1 !nop_active) else $error("two-word skip length wrong");

   a_no_skip_one: assert property ((test_active && q_phase == `BTSD_Q3 && rd_bit != ir_set)
      |=> !skip_taken ##1 !nop_active) else $error("test without skip took extra cycle");

   a_bank_sel: assert property ((accept && instr_word[`BTSD_BANK_FLAG])
      |=> data_addr[11:8] == $past(bank_select_reg) && data_rd_en) else $error("bank select not used");

   a_indexed: assert property ((accept && !instr_word[`BTSD_BANK_FLAG] && ext_set_en &&
      instr_word[7:0] <= `BTSD_ACCESS_LIM)
      |=> data_addr == 12'($past(index_base) + {4'h0, $past(instr_word[7:0])}))
      else $error("indexed offset address wrong");

   a_set_decode: assert property ((accept && instr_word[15:12] == `BTSD_OP_SET)
      |=> test_active && ir_set) else $error("set opcode not decoded");

   a_no_write: assert property (test_active |-> !data_we && !status_we)
      else $error("bit test wrote register or flags");

   a_clear_decode: assert property ((accept && instr_word[15:12] == `BTSD_OP_CLR)
      |=> test_active && !ir_set) else $error("clear opcode not decoded");

   a_access_low: assert property ((accept && !instr_word[`BTSD_BANK_FLAG] && !ext_set_en &&
      instr_word[7:0] <= `BTSD_ACCESS_LIM)
      |=> data_addr == {`BTSD_ACCESS_LO, $past(instr_word[7:0])})
      else $error("low access bank address wrong");

   a_access_high: assert property ((accept && !instr_word[`BTSD_BANK_FLAG] &&
      instr_word[7:0] > `BTSD_ACCESS_LIM)
      |=> data_addr == {`BTSD_ACCESS_HI, $past(instr_word[7:0])})
      else $error("high access bank address wrong");

   a_discard_once: assert property (discard_fetch |=> !discard_fetch)
      else $error("discard pulse longer than one clock");

   a_nop_refuse: assert property (nop_active |-> !accept && !test_active)
      else $error("instruction taken during no-op cycle");

   a_rd_window: assert property (accept |=> data_rd_en ##1 data_rd_en ##1 !data_rd_en)
      else $error("register read window length wrong");

endmodule // btsd_decoder
`default_nettype wire

//--- btsd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

// Data memory seen by the decoder; read is combinational from the address
module btsd_mem_model (
   input  wire logic        rd_en,
   input  wire logic [11:0] addr,
   output logic      [7:0]  rd_data
);
   logic [7:0] mem [0:4095];

   // Unselected reads return the inverse, never a plausible value
   assign rd_data = rd_en ? mem[addr] : ~mem[addr];
endmodule // btsd_mem_model

`default_nettype wire

//--- btsd_pkg.sv
package btsd_pkg;

   typedef enum logic [2:0] {
      BTSD_EXEC = 3'h1,
      BTSD_NOP1 = 3'h2,
      BTSD_NOP2 = 3'h4
   } btsd_state_t;

endpackage
